// *** dv/olsr_host_model.sv ***
// Purpose: host model issuing status register reads
// Assumes: go_i is high one cycle per read
// Notes: idle address flips to the inverse of its own value every cycle
module olsr_host_model
  import olsr_pkg::*;
(
  // bench control
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] addr_i,
  // read request
  output olsr_req_s req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req_o = '0;
  always @(posedge clk_i) begin
    req_o.valid <= go_i;
    req_o.addr_byte <= go_i ? addr_i : ~req_o.addr_byte;
  end
endmodule

// *** dv/olsr_top_tb.sv ***
// Purpose: bench for the open-load status register bank
// Assumes: reads go through the host model
// Notes: a six-bridge copy shares all stimulus
module olsr_top_tb import olsr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [11:0] hi = 12'h000;
  logic [11:0] lo = 12'h000;
  logic [7:0] ga [3] = '{8'h05, 8'h45, 8'h25};
  olsr_req_s req;
  olsr_rsp_s rsp;
  olsr_rsp_s rsp_s;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  initial forever #5 ref_clk = ~ref_clk;
  olsr_host_model u_host (.clk_i(ref_clk), .go_i(go), .addr_i(addr), .req_o(req));
  olsr_top u_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .ce_i(ce), .bridge_high_open_load_i(hi),
    .bridge_low_open_load_i(lo), .req_i(req), .rsp_o(rsp));
  olsr_top #(.NUM_BRIDGES(6)) u_dut_small (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .ce_i(ce),
    .bridge_high_open_load_i(hi), .bridge_low_open_load_i(lo), .req_i(req), .rsp_o(rsp_s));
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask
  function automatic logic [7:0] mp(input logic [3:0] h, input logic [3:0] l);
    for (int k = 0; k < 4; k++) begin
      mp[2*k+1] = h[k];
      mp[2*k] = l[k];
    end
  endfunction
  // one read: address, expected data, six-bridge mask, expected hit
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input logic h);
    @(posedge ref_clk) begin
      go <= 1'b1;
      addr <= a;
    end
    @(posedge ref_clk) go <= 1'b0;
    @(posedge ref_clk) #1;
    check1(rsp.valid, 1'b1);
    check1(rsp.hit, h);
    check8(rsp.data, e);
    check8(rsp_s.data, e & m);
    check1(rsp_s.hit, h);
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(8'h05, 8'h00, 8'hFF, 1'b1);
    rd(8'h45, 8'h00, 8'h0F, 1'b1);
    rd(8'h25, 8'h00, 8'h00, 1'b1);
    @(posedge ref_clk) begin
      hi <= 12'h8A1;
      lo <= 12'h358;
    end
    @(posedge ref_clk) begin
      hi <= 12'h000;
      lo <= 12'h000;
    end
    repeat (5) @(posedge ref_clk);
    rd(8'h09, 8'h00, 8'h00, 1'b0);
    rd(8'h04, 8'h00, 8'h00, 1'b0);
    rd(8'h75, 8'h00, 8'h00, 1'b0);
    rd(8'h87, mp(4'h1, 4'h8), 8'hFF, 1'b1);
    rd(8'h45, mp(4'hA, 4'h5), 8'h0F, 1'b1);
    rd(8'hA7, mp(4'h8, 4'h3), 8'h00, 1'b1);
    for (int g = 0; g < 3; g++)
      rd(ga[g], 8'h00, 8'h00, 1'b1);
    @(posedge ref_clk) hi <= 12'h001;
    rd(8'h05, 8'h02, 8'hFF, 1'b1);
    rd(8'h05, 8'h02, 8'hFF, 1'b1);
    @(posedge ref_clk) hi <= 12'h000;
    rd(8'h05, 8'h02, 8'hFF, 1'b1);
    rd(8'h05, 8'h00, 8'hFF, 1'b1);
    @(posedge ref_clk) begin
      ce <= 1'b0;
      hi <= 12'h002;
    end
    repeat (3) @(posedge ref_clk);
    @(posedge ref_clk) begin
      ce <= 1'b1;
      hi <= 12'h000;
    end
    rd(8'h05, 8'h00, 8'hFF, 1'b1);
    @(posedge ref_clk) lo <= 12'h800;
    @(posedge ref_clk) lo <= 12'h000;
    @(posedge ref_clk) rst_n <= 1'b0;
    @(posedge ref_clk) rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(8'h25, 8'h00, 8'h00, 1'b1);
    final_report();
  end
endmodule

// *** src/olsr_flag_reg.sv ***
// Purpose: one 8-bit latched, read-to-clear flag register
// Assumes: set and clear are synchronous to the clock
// Notes: set wins over a clear in the same cycle
module olsr_flag_reg
  import olsr_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  // clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // control
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] keep_i,
  input wire logic clear_i,
  // state
  output logic [WIDTH-1:0] flags_o
);

  // ----------------------------------------
  // flag storage
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_o <= WIDTH'(OLSR_FLAGS_RESET);
    end else if (ce_i) begin
      if (clear_i) begin
        flags_o <= set_i & keep_i;
      end else begin
        flags_o <= (flags_o | set_i) & keep_i;
      end
    end
  end

endmodule

// *** src/olsr_pkg.sv ***
// Purpose: constants and types for the open-load status register bank
// Assumes: one 100 MHz clock, active-low asynchronous reset
// Notes: address bytes are [op] a2 a1 a0 b1 b0 [flag] 1
package olsr_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int unsigned OLSR_NUM_BRIDGES = 12;
  localparam int unsigned OLSR_BRIDGES_PER_REG = 4;
  localparam int unsigned OLSR_NUM_REGS = 3;
  localparam int unsigned OLSR_REG_W = 8;

  // ----------------------------------------
  // address fields inside the address byte
  // ----------------------------------------
  localparam int unsigned OLSR_ADDR_HI_POS = 4;
  localparam int unsigned OLSR_ADDR_LO_POS = 2;
  localparam int unsigned OLSR_FLAG_POS = 1;
  localparam int unsigned OLSR_OP_POS = 7;
  localparam logic [2:0] OLSR_ADDR_BR_1_4 = 3'h0;
  localparam logic [2:0] OLSR_ADDR_BR_5_8 = 3'h4;
  localparam logic [2:0] OLSR_ADDR_BR_9_12 = 3'h2;
  localparam logic [1:0] OLSR_ADDR_OL_GROUP = 2'h1;
  localparam logic OLSR_ADDR_TAIL = 1'b1;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] OLSR_FLAGS_RESET = 8'h00;
  localparam logic [7:0] OLSR_READ_IDLE = 8'h00;

  // one read request with its answer
  typedef struct packed {
    logic valid;
    logic [7:0] addr_byte;
  } olsr_req_s;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [7:0] data;
  } olsr_rsp_s;

endpackage

// *** src/olsr_top.sv ***
// Purpose: open-load status register bank for twelve half-bridges
// Assumes: requests arrive synchronous to ref_clk_i
// Notes: one answer per request, one cycle later
//
// What this block does
// - an open-load event while ce_i is high sets its switch flag, held until cleared
// - all flags reset to zero, meaning no error
// - bridges five to eight answer address bits 100 then 01
// - bridges nine to twelve answer address bits 010 then 01
// - high-side flags sit on odd bits, highest bridge at D7
// - low-side flags sit on even bits, lowest bridge at D0
// - bridges one to four answer address bits 000 then 01
// - absent outputs on smaller variants always read as zero
module olsr_top
  import olsr_pkg::*;
#(
  parameter int unsigned NUM_BRIDGES = OLSR_NUM_BRIDGES
) (
  // clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // open-load detector levels, bit n-1 = bridge n
  input wire logic [OLSR_NUM_BRIDGES-1:0] bridge_high_open_load_i,
  input wire logic [OLSR_NUM_BRIDGES-1:0] bridge_low_open_load_i,
  // register read port
  input wire olsr_req_s req_i,
  output olsr_rsp_s rsp_o
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  logic frame_ok;
  logic [2:0] addr_hi;
  logic [OLSR_NUM_REGS-1:0] sel;

  assign frame_ok = req_i.valid &&
    req_i.addr_byte[OLSR_ADDR_LO_POS +: 2] == OLSR_ADDR_OL_GROUP &&
    req_i.addr_byte[0] == OLSR_ADDR_TAIL;
  assign addr_hi = req_i.addr_byte[OLSR_ADDR_HI_POS +: 3];
  assign sel[0] = frame_ok && addr_hi == OLSR_ADDR_BR_1_4;
  assign sel[1] = frame_ok && addr_hi == OLSR_ADDR_BR_5_8;
  assign sel[2] = frame_ok && addr_hi == OLSR_ADDR_BR_9_12;

  // ----------------------------------------
  // flag registers, one per bridge group
  // ----------------------------------------
  logic [OLSR_REG_W-1:0] set_vec [OLSR_NUM_REGS];
  logic [OLSR_REG_W-1:0] keep_vec [OLSR_NUM_REGS];
  logic [OLSR_REG_W-1:0] flags [OLSR_NUM_REGS];

  for (genvar g = 0; g < OLSR_NUM_REGS; g++) begin : g_reg
    for (genvar b = 0; b < OLSR_BRIDGES_PER_REG; b++) begin : g_bit
      localparam int unsigned IDX = g * OLSR_BRIDGES_PER_REG + b;
      assign set_vec[g][2*b+1] = bridge_high_open_load_i[IDX];
      assign set_vec[g][2*b] = bridge_low_open_load_i[IDX];
      assign keep_vec[g][2*b+1] = (IDX < NUM_BRIDGES);
      assign keep_vec[g][2*b] = (IDX < NUM_BRIDGES);
    end
    olsr_flag_reg #(
      .WIDTH(OLSR_REG_W)
    ) u_flags (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_sync_n),
      .ce_i(ce_i),
      .set_i(set_vec[g]),
      .keep_i(keep_vec[g]),
      .clear_i(sel[g]),
      .flags_o(flags[g])
    );
  end

  // ----------------------------------------
  // read answer
  // ----------------------------------------
  logic [OLSR_REG_W-1:0] next_data;

  always_comb begin
    next_data = OLSR_READ_IDLE;
    for (int i = 0; i < OLSR_NUM_REGS; i++) begin
      if (sel[i]) begin
        next_data = flags[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rsp_o <= '0;
    end else if (ce_i) begin
      rsp_o.valid <= req_i.valid;
      rsp_o.hit <= |sel;
      rsp_o.data <= next_data;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_group1_read: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
    ce_i && req_i.valid && req_i.addr_byte[6:2] == 5'h01 && req_i.addr_byte[0] |=> rsp_o.hit && rsp_o.data == $past(flags[0]))
    else $error("group 1 read wrong");
  a_group2_read: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
    ce_i && req_i.valid && req_i.addr_byte[6:0] == 7'h45 |=> rsp_o.hit && rsp_o.data == $past(flags[1]))
    else $error("group 2 read wrong");
  a_group3_read: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
    ce_i && req_i.valid && req_i.addr_byte[6:0] == 7'h25 |=> rsp_o.hit && rsp_o.data == $past(flags[2]))
    else $error("group 3 read wrong");
  a_flag_sets: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
    ce_i && bridge_high_open_load_i[0] |=> flags[0][1])
    else $error("high flag not set");
  a_flag_holds: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
    ce_i && flags[1][0] && !sel[1] |=> flags[1][0])
    else $error("flag lost without read");
  a_high_odd: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
    ce_i && NUM_BRIDGES > 11 && bridge_high_open_load_i[11] |=> flags[2][7])
    else $error("bridge 12 high not at D7");
  a_low_even: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
    ce_i && NUM_BRIDGES > 8 && bridge_low_open_load_i[8] |=> flags[2][0])
    else $error("bridge 9 low not at D0");
  a_read_clears: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
    ce_i && sel[0] && bridge_low_open_load_i[3:0] == 4'h0 && bridge_high_open_load_i[3:0] == 4'h0
    |=> flags[0] == 8'h00)
    else $error("read did not clear");
  a_absent_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
    NUM_BRIDGES < 12 |-> !flags[2][7])
    else $error("absent bridge flag set");
  a_reset_zero: assert property (@(posedge ref_clk_i)
    $rose(rst_sync_n) |-> flags[0] == 8'h00 && flags[1] == 8'h00 && flags[2] == 8'h00)
    else $error("flags not zero after reset");
  a_reset_answer: assert property (@(posedge ref_clk_i)
    $rose(rst_sync_n) |-> rsp_o == '0)
    else $error("answer not idle after reset");
  a_set_wins: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
    ce_i && sel[0] && bridge_high_open_load_i[0] |=> flags[0][1])
    else $error("read cleared an active fault");
  a_one_group: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
    $onehot0(sel))
    else $error("two groups selected");

  // ----------------------------------------
  // checks, answer framing
  // ----------------------------------------
  a_valid_echo: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
    ce_i && req_i.valid |=> rsp_o.valid)
    else $error("request not answered");
  a_idle_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
    ce_i && !req_i.valid |=> !rsp_o.valid && !rsp_o.hit && rsp_o.data == 8'h00)
    else $error("answer without request");
  a_refused_miss: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
    ce_i && req_i.valid && !(req_i.addr_byte[0] && req_i.addr_byte[6:2] inside {5'h01, 5'h11, 5'h09})
    |=> rsp_o.valid && !rsp_o.hit && rsp_o.data == 8'h00)
    else $error("bad address answered");
  a_refused_keeps: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
    ce_i && req_i.valid && !(req_i.addr_byte[0] && req_i.addr_byte[6:2] inside {5'h01, 5'h11, 5'h09})
    |=> (flags[0] & $past(flags[0])) == $past(flags[0]) && (flags[2] & $past(flags[2])) == $past(flags[2]))
    else $error("bad address cleared flags");
  a_freeze: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
    !ce_i |=> $stable(rsp_o) && $stable(flags[0]) && $stable(flags[1]) && $stable(flags[2]))
    else $error("state moved while disabled");

  // ----------------------------------------
  // checks, per group
  // ----------------------------------------
  for (genvar g = 0; g < OLSR_NUM_REGS; g++) begin : g_group_chk
    a_no_loss: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
      ce_i && !sel[g] |=> (flags[g] & $past(flags[g])) == $past(flags[g]))
      else $error("flag lost without read");
    a_clear_read: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
      ce_i && sel[g] |=> (flags[g] & ~$past(set_vec[g])) == 8'h00)
      else $error("read left a stale flag");
    a_group_answer: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
      ce_i && sel[g] |=> rsp_o.valid && rsp_o.hit && rsp_o.data == $past(flags[g]))
      else $error("group answer wrong");
  end

  // ----------------------------------------
  // checks, per bridge
  // ----------------------------------------
  for (genvar n = 0; n < OLSR_NUM_BRIDGES; n++) begin : g_bridge_chk
    localparam int unsigned GR = n / OLSR_BRIDGES_PER_REG;
    localparam int unsigned HI = 2 * (n % OLSR_BRIDGES_PER_REG) + 1;
    localparam int unsigned LO = 2 * (n % OLSR_BRIDGES_PER_REG);
    a_high_map: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
      ce_i && NUM_BRIDGES > n && bridge_high_open_load_i[n] |=> flags[GR][HI])
      else $error("high flag in wrong bit");
    a_low_map: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
      ce_i && NUM_BRIDGES > n && bridge_low_open_load_i[n] |=> flags[GR][LO])
      else $error("low flag in wrong bit");
    a_high_held: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
      ce_i && flags[GR][HI] && !sel[GR] |=> flags[GR][HI])
      else $error("high flag lost without read");
    a_high_read: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
      ce_i && sel[GR] && flags[GR][HI] |=> rsp_o.data[HI])
      else $error("high flag missing from answer");
    a_low_read: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
      ce_i && sel[GR] && flags[GR][LO] |=> rsp_o.data[LO])
      else $error("low flag missing from answer");
    a_absent_bits: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
      NUM_BRIDGES <= n |-> !flags[GR][HI] && !flags[GR][LO])
      else $error("absent bridge flag held");
    a_absent_read: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
      ce_i && sel[GR] && NUM_BRIDGES <= n |=> !rsp_o.data[HI] && !rsp_o.data[LO])
      else $error("absent bridge flag answered");
  end

endmodule
